/* File: rtl/cec_top.sv */
// capacitive electrode configuration registers and touch evaluation
//
// Notes on behaviour
// - timeout zero never forces recalibration
// - recalibrate after n touched task executions
// - touch when reading exceeds baseline by threshold
// - four enable bits, one per electrode
// - sleep scan period from 4-bit code table
// - shutdown wake scans only selected electrode
// - 7-bit wake threshold for wake electrode
// - resolution accepts only codes 8 to 11
// - new resolution applied only after restart
// - wake enable stops run scanning, resets zero
// - stuck recalibration only with stuck enable
//
// Register access over AHB-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "cec_defines.svh"
module cec_top #(
	parameter int unsigned MS_CYCLES = `CEC_MS_CYCLES
)(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// sensing front-end
	input  wire logic        sampleValid,
	input  wire logic [1:0]  sampleIndex,
	input  wire logic [15:0] sampleData,
	input  wire logic        shutdownPin,
	output logic [3:0]       electrodeScan,
	output logic             lowPowerStrobe,
	output logic [3:0]       scanResolution,
	output logic [3:0]       touchStatus,
	output logic             wakeRequest
);
	// ***********************************************
	// registers
	// ***********************************************
	logic       stuck_recal_enable;
	logic       capacitive_wake_enable;
	logic [7:0] stuck_timeout_count;
	logic [6:0] electrode_threshold [4];
	logic [3:0] electrode_on_bit;
	logic [3:0] sleep_scan_code;
	logic [1:0] wake_electrode_index;
	logic [6:0] wake_threshold;
	logic [3:0] sample_resolution_code;
	logic       wakeFlag;
	logic [31:0] rdData;

	logic        dWrite;
	logic [7:0]  dAddr;
	logic        next_dWrite;
	logic [7:0]  next_dAddr;
	logic [31:0] next_rdData;
	logic        aValid;
	logic        restartReq;
	logic        wakeHit;

	// ***********************************************
	// pin synchroniser and mode
	// ***********************************************
	logic shutSync1;
	logic shutSync2;
	cec_pkg::cec_mode_t mode;
	cec_pkg::cec_mode_t next_mode;
	logic                resLoad;
	logic                next_resLoad;
	logic [3:0]          next_scanResolution;

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			shutSync1 <= 1'b0;
			shutSync2 <= 1'b0;
		end
		else
		begin
			shutSync1 <= shutdownPin;
			shutSync2 <= shutSync1;
		end
	end

	always_comb
	begin
		next_mode = mode;
		case (mode)
			cec_pkg::CEC_IDLE: next_mode = cec_pkg::CEC_RUN;
			cec_pkg::CEC_RUN:
				if (shutSync2 && capacitive_wake_enable)
					next_mode = cec_pkg::CEC_WAKE;
			cec_pkg::CEC_WAKE:
				if (!shutSync2 || !capacitive_wake_enable)
					next_mode = cec_pkg::CEC_RUN;
			default: next_mode = cec_pkg::CEC_IDLE;
		endcase
		if (restartReq)
			next_mode = cec_pkg::CEC_IDLE;
		// resolution taken only at a restart
		next_resLoad        = restartReq;
		next_scanResolution = resLoad ? sample_resolution_code : scanResolution;
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			mode           <= cec_pkg::CEC_IDLE;
			resLoad        <= 1'b0;
			scanResolution <= `CEC_RES_RST;
		end
		else
		begin
			mode           <= next_mode;
			resLoad        <= next_resLoad;
			scanResolution <= next_scanResolution;
		end
	end

	// ***********************************************
	// scan selection
	// ***********************************************
	cec_scan_if scanLink ();
	logic [3:0] scanned;

	assign scanLink.scanCode = sleep_scan_code;
	assign scanLink.run      = (mode == cec_pkg::CEC_WAKE);

	cec_scan_timer #(.MS_CYCLES(MS_CYCLES)) uTimer (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.scan    (scanLink.timer)
	);

	always_comb
	begin
		scanned = 4'h0;
		// no run scanning while wake enabled
		if (mode == cec_pkg::CEC_RUN && !capacitive_wake_enable)
			scanned = electrode_on_bit;
		// only the wake electrode in shutdown
		else if (mode == cec_pkg::CEC_WAKE)
			scanned[wake_electrode_index] = 1'b1;
	end

	assign electrodeScan  = scanned;
	assign lowPowerStrobe = scanLink.tick;

	// ***********************************************
	// per-electrode evaluation
	// ***********************************************
	logic [3:0] touchRaw;

	for (genvar i = 0; i < 4; i++)
	begin : gElec
		logic [15:0] baseline;
		logic [15:0] next_baseline;
		logic        haveBase;
		logic        next_haveBase;
		logic [7:0]  stuckCnt;
		logic [7:0]  next_stuckCnt;
		logic        touched;
		logic        next_touched;
		logic [6:0]  thr;
		logic        hit;

		assign thr = (mode == cec_pkg::CEC_WAKE) ? wake_threshold : electrode_threshold[i];

		always_comb
		begin
			next_baseline = baseline;
			next_haveBase = haveBase;
			next_stuckCnt = stuckCnt;
			next_touched  = touched;
			// reading at least baseline plus threshold
			hit = ({1'b0, sampleData} >= ({1'b0, baseline} + {10'h0, thr}));
			if (!scanned[i] || restartReq)
			begin
				next_haveBase = 1'b0;
				next_stuckCnt = 8'h0;
				next_touched  = 1'b0;
			end
			else if (sampleValid && sampleIndex == 2'(i))
			begin
				if (!haveBase)
				begin
					next_baseline = sampleData;
					next_haveBase = 1'b1;
				end
				else if (!hit)
				begin
					next_touched  = 1'b0;
					next_stuckCnt = 8'h0;
				end
				else if (stuck_recal_enable && stuck_timeout_count != `CEC_TIMEOUT_OFF)
				begin
					if (stuckCnt + 8'h1 >= stuck_timeout_count)
					begin
						next_baseline = sampleData;
						next_stuckCnt = 8'h0;
						next_touched  = 1'b0;
					end
					else
					begin
						next_stuckCnt = stuckCnt + 8'h1;
						next_touched  = 1'b1;
					end
				end
				else
					next_touched = 1'b1;
			end
		end

		always_ff @(posedge ref_clk or negedge rst_b)
		begin
			if (!rst_b)
			begin
				baseline <= 16'h0;
				haveBase <= 1'b0;
				stuckCnt <= 8'h0;
				touched  <= 1'b0;
			end
			else
			begin
				baseline <= next_baseline;
				haveBase <= next_haveBase;
				stuckCnt <= next_stuckCnt;
				touched  <= next_touched;
			end
		end

		assign touchRaw[i] = touched;
	end

	assign touchStatus = (mode == cec_pkg::CEC_RUN) ? touchRaw : 4'h0;
	assign wakeHit     = (mode == cec_pkg::CEC_WAKE) && (touchRaw != 4'h0);
	assign wakeRequest = wakeFlag;

	// ***********************************************
	// ahb-lite slave, zero wait states
	// ***********************************************
	assign aValid    = hsel && htrans[1] && hready;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdData;

	always_comb
	begin
		next_dWrite = aValid && hwrite;
		next_dAddr  = haddr[7:0];
		next_rdData = 32'h0;
		if (aValid && !hwrite)
		begin
			if (haddr[7:0] == `CEC_OFS_CFG)
			begin
				next_rdData[`CEC_CFG_STUCK_BIT] = stuck_recal_enable;
				next_rdData[`CEC_CFG_WAKE_BIT]  = capacitive_wake_enable;
			end
			else if (haddr[7:0] == `CEC_OFS_TIMEOUT)
				next_rdData[7:0] = stuck_timeout_count;
			else if (haddr[7:0] >= `CEC_OFS_THR0 && haddr[7:0] < `CEC_OFS_ENABLES
				&& haddr[1:0] == 2'h0)
				next_rdData[6:0] = electrode_threshold[haddr[3:2] - 2'h2];
			else if (haddr[7:0] == `CEC_OFS_ENABLES)
				next_rdData[3:0] = electrode_on_bit;
			else if (haddr[7:0] == `CEC_OFS_SCANCODE)
				next_rdData[3:0] = sleep_scan_code;
			else if (haddr[7:0] == `CEC_OFS_WAKEIDX)
				next_rdData[1:0] = wake_electrode_index;
			else if (haddr[7:0] == `CEC_OFS_WAKETHR)
				next_rdData[6:0] = wake_threshold;
			else if (haddr[7:0] == `CEC_OFS_RES)
				next_rdData[3:0] = sample_resolution_code;
			else if (haddr[7:0] == `CEC_OFS_STATUS)
			begin
				next_rdData[3:0] = touchStatus;
				next_rdData[`CEC_STAT_WAKE_BIT] = wakeFlag;
				next_rdData[`CEC_STAT_RES_LSB +: 4] = scanResolution;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			dWrite <= 1'b0;
			dAddr  <= 8'h0;
			rdData <= 32'h0;
		end
		else
		begin
			dWrite <= next_dWrite;
			dAddr  <= next_dAddr;
			rdData <= next_rdData;
		end
	end

	// ***********************************************
	// register writes in the data phase
	// ***********************************************
	assign restartReq = dWrite && dAddr == `CEC_OFS_RESTART && hwdata[0];

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			stuck_recal_enable     <= 1'b0;
			capacitive_wake_enable <= 1'b0;
			stuck_timeout_count    <= `CEC_TIMEOUT_RST;
			for (int k = 0; k < 4; k++)
				electrode_threshold[k] <= `CEC_THR_RST;
			electrode_on_bit       <= `CEC_ENABLES_RST;
			sleep_scan_code        <= `CEC_SCAN_RST;
			wake_electrode_index   <= `CEC_WAKEIDX_RST;
			wake_threshold         <= `CEC_WAKETHR_RST;
			sample_resolution_code <= `CEC_RES_RST;
			wakeFlag               <= 1'b0;
		end
		else
		begin
			// set wins over a clear in the same cycle
			if (wakeHit)
				wakeFlag <= 1'b1;
			else if (dWrite && dAddr == `CEC_OFS_STATUS && hwdata[`CEC_STAT_WAKE_BIT])
				wakeFlag <= 1'b0;
			// the restart also drops the wake enable
			if (restartReq)
				capacitive_wake_enable <= 1'b0;
			else if (dWrite)
			begin
				if (dAddr == `CEC_OFS_CFG)
				begin
					stuck_recal_enable     <= hwdata[`CEC_CFG_STUCK_BIT];
					capacitive_wake_enable <= hwdata[`CEC_CFG_WAKE_BIT];
				end
				else if (dAddr == `CEC_OFS_TIMEOUT)
					stuck_timeout_count <= hwdata[7:0];
				else if (dAddr >= `CEC_OFS_THR0 && dAddr < `CEC_OFS_ENABLES
					&& dAddr[1:0] == 2'h0)
					electrode_threshold[dAddr[3:2] - 2'h2] <= hwdata[6:0];
				else if (dAddr == `CEC_OFS_ENABLES)
					electrode_on_bit <= hwdata[3:0];
				// code stored as given, no ms meaning
				else if (dAddr == `CEC_OFS_SCANCODE)
					sleep_scan_code <= hwdata[3:0];
				else if (dAddr == `CEC_OFS_WAKEIDX)
					wake_electrode_index <= hwdata[1:0];
				else if (dAddr == `CEC_OFS_WAKETHR)
					wake_threshold <= hwdata[6:0];
				else if (dAddr == `CEC_OFS_RES && hwdata[31:4] == 28'h0
					&& hwdata[3:0] >= `CEC_RES_MIN && hwdata[3:0] <= `CEC_RES_MAX)
					sample_resolution_code <= hwdata[3:0];
			end
		end
	end
endmodule

/* File: include/cec_defines.svh */
// constants for the capacitive electrode configuration block
`ifndef CEC_DEFINES_SVH
`define CEC_DEFINES_SVH

// ***********************************************
// register offsets (byte addresses)
// ***********************************************
`define CEC_OFS_CFG      8'h00
`define CEC_OFS_TIMEOUT  8'h04
`define CEC_OFS_THR0     8'h08
`define CEC_OFS_ENABLES  8'h18
`define CEC_OFS_SCANCODE 8'h1c
`define CEC_OFS_WAKEIDX  8'h20
`define CEC_OFS_WAKETHR  8'h24
`define CEC_OFS_RES      8'h28
`define CEC_OFS_STATUS   8'h2c
`define CEC_OFS_RESTART  8'h30

// ***********************************************
// field positions
// ***********************************************
`define CEC_CFG_STUCK_BIT 4
`define CEC_CFG_WAKE_BIT  2
`define CEC_STAT_WAKE_BIT 4
`define CEC_STAT_RES_LSB  8

// ***********************************************
// reset values and limits
// ***********************************************
`define CEC_TIMEOUT_RST 8'h00
`define CEC_THR_RST     7'h0a
`define CEC_ENABLES_RST 4'h0
`define CEC_SCAN_RST    4'h0
`define CEC_WAKEIDX_RST 2'h0
`define CEC_WAKETHR_RST 7'h0a
`define CEC_RES_RST     4'h8
`define CEC_RES_MIN     4'h8
`define CEC_RES_MAX     4'hb
`define CEC_TIMEOUT_OFF 8'h00

// ***********************************************
// timing
// ***********************************************
`define CEC_CLK_NS    10
`define CEC_MS_NS     1000000
`define CEC_MS_CYCLES (`CEC_MS_NS / `CEC_CLK_NS)

// sleep scan intervals in ms, by code
`define CEC_LP_MS_0  9'd1
`define CEC_LP_MS_1  9'd5
`define CEC_LP_MS_2  9'd10
`define CEC_LP_MS_3  9'd15
`define CEC_LP_MS_4  9'd20
`define CEC_LP_MS_5  9'd30
`define CEC_LP_MS_6  9'd40
`define CEC_LP_MS_7  9'd50
`define CEC_LP_MS_8  9'd75
`define CEC_LP_MS_9  9'd100
`define CEC_LP_MS_10 9'd125
`define CEC_LP_MS_11 9'd150
`define CEC_LP_MS_12 9'd200
`define CEC_LP_MS_13 9'd300
`define CEC_LP_MS_14 9'd400
`define CEC_LP_MS_15 9'd500

`endif

/* File: include/cec_pkg.sv */
// types of the capacitive electrode configuration block
package cec_pkg;
	// gray order: idle -> run -> wake watch
	typedef enum logic [1:0]
	{
		CEC_IDLE = 2'b00,
		CEC_RUN  = 2'b01,
		CEC_WAKE = 2'b11
	} cec_mode_t;
endpackage

/* File: include/cec_scan_if.sv */
// link between the controller and the sleep scan timer
`timescale 1ns/100ps
interface cec_scan_if;
	logic [3:0] scanCode;
	logic       run;
	logic       tick;
	modport timer (input scanCode, input run, output tick);
	modport ctrl  (output scanCode, output run, input tick);
endinterface

/* File: rtl/cec_scan_timer.sv */
// sleep scan interval timer driven by the 4-bit scan code
`timescale 1ns/100ps
`include "cec_defines.svh"
module cec_scan_timer #(
	parameter int unsigned MS_CYCLES = `CEC_MS_CYCLES
)(
	// clock and reset
	input  wire logic  ref_clk,
	input  wire logic  rst_b,
	// controller side
	cec_scan_if.timer  scan
);
	logic [16:0] msCnt;
	logic [16:0] next_msCnt;
	logic [8:0]  ivCnt;
	logic [8:0]  next_ivCnt;
	logic        tick;
	logic        next_tick;
	logic [8:0]  intervalMs;
	logic        msTick;

	// ***********************************************
	// code to interval
	// ***********************************************
	// non-linear code table
	always_comb
	begin
		case (scan.scanCode)
			4'h0:    intervalMs = `CEC_LP_MS_0;
			4'h1:    intervalMs = `CEC_LP_MS_1;
			4'h2:    intervalMs = `CEC_LP_MS_2;
			4'h3:    intervalMs = `CEC_LP_MS_3;
			4'h4:    intervalMs = `CEC_LP_MS_4;
			4'h5:    intervalMs = `CEC_LP_MS_5;
			4'h6:    intervalMs = `CEC_LP_MS_6;
			4'h7:    intervalMs = `CEC_LP_MS_7;
			4'h8:    intervalMs = `CEC_LP_MS_8;
			4'h9:    intervalMs = `CEC_LP_MS_9;
			4'ha:    intervalMs = `CEC_LP_MS_10;
			4'hb:    intervalMs = `CEC_LP_MS_11;
			4'hc:    intervalMs = `CEC_LP_MS_12;
			4'hd:    intervalMs = `CEC_LP_MS_13;
			4'he:    intervalMs = `CEC_LP_MS_14;
			default: intervalMs = `CEC_LP_MS_15;
		endcase
	end

	// ***********************************************
	// ms divider and interval counter
	// ***********************************************
	assign msTick = (msCnt == 17'(MS_CYCLES - 1));

	always_comb
	begin
		next_msCnt = msTick ? 17'h0 : msCnt + 17'h1;
		next_ivCnt = ivCnt;
		next_tick  = 1'b0;
		if (!scan.run)
		begin
			next_msCnt = 17'h0;
			next_ivCnt = 9'h0;
		end
		else if (msTick)
		begin
			if (ivCnt + 9'h1 >= intervalMs)
			begin
				next_ivCnt = 9'h0;
				next_tick  = 1'b1;
			end
			else
				next_ivCnt = ivCnt + 9'h1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			msCnt <= 17'h0;
			ivCnt <= 9'h0;
			tick  <= 1'b0;
		end
		else
		begin
			msCnt <= next_msCnt;
			ivCnt <= next_ivCnt;
			tick  <= next_tick;
		end
	end

	assign scan.tick = tick;
endmodule

/* File: tb/cec_top_asserts.sv */
// port assertions for the capacitive electrode configuration block
`timescale 1ns/100ps
module cec_top_asserts #(
	parameter int unsigned MS_CYCLES = 10
)(
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        rst_b,
	// ahb-lite slave
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	// sensing front-end
	input wire logic        sampleValid,
	input wire logic [1:0]  sampleIndex,
	input wire logic [15:0] sampleData,
	input wire logic        shutdownPin,
	input wire logic [3:0]  electrodeScan,
	input wire logic        lowPowerStrobe,
	input wire logic [3:0]  scanResolution,
	input wire logic [3:0]  touchStatus,
	input wire logic        wakeRequest
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// ****************
	// checks
	// ****************
	a_bus_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1)
		else $error("bus response not okay");
	a_read_idle: assert property (!$past(hsel && htrans[1] && !hwrite) |-> hrdata == 32'h0)
		else $error("read data outside a read data phase");
	a_res_legal: assert property ($changed(scanResolution) |-> scanResolution inside {[4'h8:4'hb]})
		else $error("applied resolution outside legal codes");
	a_res_reset: assert property ($rose(rst_b) |-> scanResolution == 4'h8)
		else $error("resolution not default after reset");
	a_touch_cause: assert property ((touchStatus & ~$past(touchStatus)) != 4'h0
		|-> $past(sampleValid) && (touchStatus & ~$past(touchStatus)) == 4'h1 << $past(sampleIndex))
		else $error("touch without a sample on that electrode");
	a_wake_cause: assert property ($rose(wakeRequest) |-> $past(sampleValid) || $past(sampleValid, 2))
		else $error("wake flag without a sample");
	a_strobe_space: assert property (lowPowerStrobe |=> !lowPowerStrobe [*8])
		else $error("sleep scan strobes too close");
	a_strobe_one: assert property (lowPowerStrobe |-> $onehot(electrodeScan) && touchStatus == 4'h0)
		else $error("sleep scan not on a single electrode");
	c_touch: cover property ($rose(touchStatus[1]));
	c_wake: cover property ($rose(wakeRequest));
	c_res: cover property ($changed(scanResolution));
endmodule
bind cec_top cec_top_asserts #(.MS_CYCLES(MS_CYCLES)) u_chk (.ref_clk, .rst_b, .hsel, .haddr,
	.htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .sampleValid,
	.sampleIndex, .sampleData, .shutdownPin, .electrodeScan, .lowPowerStrobe, .scanResolution,
	.touchStatus, .wakeRequest);

/* File: tb/cec_fe_model.sv */
// behavioural model of the four sensing electrodes and their front-end
`timescale 1ns/100ps
module cec_fe_model (
	// clock
	input wire logic        ref_clk,
	// front-end
	input wire logic [3:0]  electrodeScan,
	input wire logic        lowPowerStrobe,
	output logic            sampleValid,
	output logic [1:0]      sampleIndex,
	output logic [15:0]     sampleData
);
	logic        req = 1'b0;
	logic        pend = 1'b0;
	logic [1:0]  reqIdx = 2'h0;
	logic [15:0] reqVal = 16'h0;
	logic [15:0] wakeLevel = 16'h0;
	initial
	begin
		sampleValid = 1'b0;
		sampleIndex = 2'h0;
		sampleData = 16'h0;
	end
	// reading is not held between samples: it toggles every cycle
	always @(posedge ref_clk)
	begin
		pend <= lowPowerStrobe;
		sampleValid <= pend | req;
		sampleIndex <= !pend ? reqIdx : electrodeScan[3] ? 2'h3 : electrodeScan[2] ? 2'h2
			: electrodeScan[1] ? 2'h1 : 2'h0;
		sampleData <= pend ? wakeLevel : req ? reqVal : ~sampleData;
	end
	task automatic send(input logic [1:0] idx, input logic [15:0] val);
		reqIdx <= idx;
		reqVal <= val;
		req <= 1'b1;
		@(posedge ref_clk);
		req <= 1'b0;
		@(posedge ref_clk);
	endtask
endmodule

/* File: tb/capacitive_electrode_config_bench.sv */
// self-checking bench for the capacitive electrode configuration block
`timescale 1ns/100ps
module capacitive_electrode_config_bench;
	localparam int unsigned MSC = 10;
	logic        ref_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic        shutdownPin = 1'b0;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic        sampleValid;
	logic [1:0]  sampleIndex;
	logic [15:0] sampleData;
	logic [3:0]  electrodeScan;
	logic        lowPowerStrobe;
	logic [3:0]  scanResolution;
	logic [3:0]  touchStatus;
	logic        wakeRequest;
	logic [31:0] rd;
	int          fails = 0;
	int          checked = 0;
	int          n;
	logic [7:0]  adr [13] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20,
		8'h24, 8'h28, 8'h2c, 8'h40};
	logic [11:0] rst [13] = '{0, 0, 10, 10, 10, 10, 0, 0, 0, 10, 8, 12'h800, 0};
	logic [11:0] msk [13] = '{12'h14, 12'hff, 12'h7f, 12'h7f, 12'h7f, 12'h7f, 15, 15, 3, 12'h7f,
		8, 12'h800, 0};
	logic [7:0]  scfg [4] = '{8'h10, 8'h10, 8'h00, 8'h10};
	logic [7:0]  stim [4] = '{3, 0, 3, 1};
	int          lpms [16] = '{1, 5, 10, 15, 20, 30, 40, 50, 75, 100, 125, 150, 200, 300, 400, 500};
	always #5 ref_clk = ~ref_clk;
	cec_top #(.MS_CYCLES(MSC)) u_dut (.ref_clk, .rst_b, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .sampleValid,
		.sampleIndex, .sampleData, .shutdownPin, .electrodeScan, .lowPowerStrobe,
		.scanResolution, .touchStatus, .wakeRequest);
	cec_fe_model u_fe (.ref_clk, .electrodeScan, .lowPowerStrobe, .sampleValid, .sampleIndex,
		.sampleData);
	// ****************
	// tasks
	// ****************
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(what, exp, rd);
	endtask
	// touch state is looked at two cycles after it updates
	task automatic smp(input logic [1:0] i, input logic [15:0] v, input logic [3:0] e, string s);
		u_fe.send(i, v);
		repeat (2) @(posedge ref_clk);
		chk(s, 32'(e), 32'(touchStatus));
	endtask
	task automatic strobe;
		do @(posedge ref_clk); while (lowPowerStrobe !== 1'b1);
	endtask
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		// the sleep interval sweep needs about 61k cycles at most
		#800000;
		fails++;
		finish_test;
	end
	// ****************
	// tests
	// ****************
	initial
	begin
		repeat (10) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		for (int i = 0; i < 13; i++)
		begin
			rdchk("reset value", adr[i], 32'(rst[i]));
			wr(adr[i], 32'hffffffff);
			rdchk("written value", adr[i], 32'(msk[i]));
		end
		wr(8'h00, 32'h0);
		wr(8'h28, 32'hb);
		rdchk("resolution", 8'h28, 32'hb);
		chk("resolution before restart", 32'h8, 32'(scanResolution));
		wr(8'h30, 32'h1);
		repeat (4) @(posedge ref_clk);
		chk("resolution after restart", 32'hb, 32'(scanResolution));
		wr(8'h18, 32'h3);
		wr(8'h0c, 32'd20);
		repeat (3) @(posedge ref_clk);
		smp(2'h1, 16'd100, 4'h0, "baseline");
		smp(2'h1, 16'd119, 4'h0, "below threshold");
		smp(2'h1, 16'd120, 4'h2, "at threshold");
		smp(2'h2, 16'd900, 4'h2, "disabled electrode");
		smp(2'h2, 16'd900, 4'h2, "disabled electrode");
		wr(8'h18, 32'h1);
		repeat (3) @(posedge ref_clk);
		chk("touch after disable", 32'h0, 32'(touchStatus));
		for (int c = 0; c < 4; c++)
		begin
			wr(8'h30, 32'h1);
			wr(8'h00, 32'(scfg[c]));
			wr(8'h04, 32'(stim[c]));
			repeat (3) @(posedge ref_clk);
			smp(2'h0, 16'd100, 4'h0, "stuck baseline");
			for (int k = 1; k <= 4; k++)
				// electrode 0 still holds threshold 127 from the all-ones write
				smp(2'h0, 16'd300, (scfg[c] != 0 && stim[c] != 0 && k >= stim[c]) ? 4'h0 : 4'h1,
					"stuck touch");
		end
		wr(8'h20, 32'h2);
		wr(8'h24, 32'd30);
		// fastest sleep scan, so each wait below spans several strobes
		wr(8'h1c, 32'h0);
		wr(8'h18, 32'hf);
		wr(8'h00, 32'h4);
		repeat (3) @(posedge ref_clk);
		chk("run scan with wake enable", 32'h0, 32'(electrodeScan));
		u_fe.wakeLevel <= 16'd100;
		shutdownPin <= 1'b1;
		repeat (40) @(posedge ref_clk);
		chk("wake scan", 32'h4, 32'(electrodeScan));
		u_fe.wakeLevel <= 16'd129;
		repeat (40) @(posedge ref_clk);
		chk("wake below threshold", 32'h0, 32'(wakeRequest));
		u_fe.wakeLevel <= 16'd130;
		repeat (40) @(posedge ref_clk);
		chk("wake at threshold", 32'h1, 32'(wakeRequest));
		rdchk("status in wake watch", 8'h2c, 32'hb10);
		for (int c = 0; c < 16; c++)
		begin
			wr(8'h1c, 32'(c));
			strobe;
			strobe;
			n = 0;
			do
			begin
				@(posedge ref_clk);
				n++;
			end
			while (lowPowerStrobe !== 1'b1);
			chk("scan interval", 32'(lpms[c] * MSC), 32'(n));
		end
		finish_test;
	end
endmodule
